/* File: pkg/sfc_defines.vh */
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// Opcodes
`define SFC_OP_SET_WRITE_LATCH_CMD_SET  8'h06
`define SFC_OP_SET_WRITE_LATCH_CMD_CLR  8'h04
`define SFC_OP_SR_RD_LO  8'h05
`define SFC_OP_SR_RD_HI  8'h35
`define SFC_OP_SR_WR     8'h01
`define SFC_OP_SR_VOL    8'h50
`define SFC_OP_READ      8'h03
`define SFC_OP_FAST      8'h0B
`define SFC_OP_DUAL_OUT  8'h3B
`define SFC_OP_QUAD_OUT  8'h6B
`define SFC_OP_DUAL_IO   8'hBB
`define SFC_OP_QUAD_IO   8'hEB
`define SFC_OP_WRAP_RD   8'h0C
`define SFC_OP_DTR_QIO   8'hED
`define SFC_OP_SET_WRAP  8'h77
`define SFC_OP_PGM       8'h02
`define SFC_OP_QPGM      8'h32
`define SFC_OP_SECT_ER   8'h20
`define SFC_OP_BLK32_ER  8'h52
`define SFC_OP_BLK64_ER  8'hD8
`define SFC_OP_CHIP_ER1  8'hC7
`define SFC_OP_CHIP_ER2  8'h60
`define SFC_OP_SEC_ER    8'h44
`define SFC_OP_SEC_PGM   8'h42
`define SFC_OP_SEC_RD    8'h48
`define SFC_OP_ID_LEG    8'h90
`define SFC_OP_ID        8'h9F
`define SFC_OP_SFDP      8'h5A
`define SFC_OP_QUAD_ON   8'h38
`define SFC_OP_QUAD_OFF  8'hFF

// Status layout
`define SFC_SR_BUSY_BIT  0
`define SFC_SR_WEL_BIT   1
`define SFC_SR_CMP_BIT   14
`define SFC_SR_WR_MASK   16'h79FC
`define SFC_SR_RESET     16'h0000

// Dummy clocks per command
`define SFC_DUMMY_SPI    5'h08
`define SFC_DUMMY_QPI    5'h04
`define SFC_DUMMY_QIO    5'h04
`define SFC_DUMMY_DTR    5'h09

// Wrap bits sampled on this clock (0 based) after the opcode
`define SFC_WRAP_CLK     4'h6

// Security register window
`define SFC_SEC_MIN      4'h1
`define SFC_SEC_MAX      4'h3

// Self-timed status write
`define SFC_CLK_NS       5
`define SFC_TW_NS        1000000
`define SFC_TW_CYC       (`SFC_TW_NS / `SFC_CLK_NS)

`endif

/* File: logic/sfc_fifo.v */
`timescale 1ns/1ps
module sfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rstn_i,
  input wire flush_i,
  input wire in_valid_i,
  output reg in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output reg out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_ready_i & out_valid_o;
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Head word sits in the storage registers
  assign out_data_o = mem_q[rp_q];

  // Storage write, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Pointers and registered flags
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else if (flush_i) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH - 1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH - 1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != DEPTH);
      out_valid_o <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule

/* File: logic/sfc_cmd_status.v */
`timescale 1ns/1ps
`include "sfc_defines.vh"
module sfc_cmd_status #(
  parameter [23:0] TW_CYC = `SFC_TW_CYC,
  parameter [7:0] MAKER_ID = 8'hA5,
  parameter [15:0] DEV_ID = 16'h5A3C,
  parameter [7:0] LEGACY_ID = 8'h3C,
  parameter FIFO_DEPTH = 8
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire [3:0] io_i,
  output reg [3:0] io_o,
  output reg [3:0] io_oe_n_o,
  output reg [15:0] status_o,
  output reg write_latch_flag_o,
  output reg cycle_active_flag_o,
  output reg quad_command_mode_o,
  output reg [2:0] wrap_bits_o,
  output reg op_start_o,
  output reg [7:0] op_code_o,
  output reg [23:0] op_addr_o,
  input wire op_done_i,
  output reg rd_req_o,
  output reg [23:0] rd_addr_o,
  input wire [7:0] rd_data_i,
  input wire rd_valid_i,
  output wire rd_ready_o,
  output reg [7:0] pgm_data_o,
  output reg pgm_valid_o
);
  // MAKER_ID, DEV_ID and LEGACY_ID defaults are arbitrary values
  localparam PH_CMD = 3'd0;
  localparam PH_ADDR = 3'd1;
  localparam PH_MODE = 3'd2;
  localparam PH_DUMMY = 3'd3;
  localparam PH_DOUT = 3'd4;
  localparam PH_DIN = 3'd5;
  localparam PH_SKIP = 3'd6;

  // Lane count for the current phase
  function [2:0] lane_w;
    input [7:0] c;
    input [2:0] ph;
    input q;
    begin
      lane_w = 3'd1;
      if (q) begin
        lane_w = 3'd4;
      end else if (ph != PH_CMD) begin
        case (c)
          `SFC_OP_DUAL_IO: lane_w = 3'd2;
          `SFC_OP_DUAL_OUT: lane_w = (ph == PH_DOUT) ? 3'd2 : 3'd1;
          `SFC_OP_QUAD_OUT: lane_w = (ph == PH_DOUT) ? 3'd4 : 3'd1;
          `SFC_OP_QUAD_IO, `SFC_OP_DTR_QIO: lane_w = 3'd4;
          `SFC_OP_QPGM: lane_w = (ph == PH_DIN) ? 3'd4 : 3'd1;
          `SFC_OP_SET_WRAP: lane_w = 3'd4;
          default: lane_w = 3'd1;
        endcase
      end
    end
  endfunction

  // Shift lanes into a byte, highest lane is the more significant bit
  function [7:0] shin;
    input [7:0] s;
    input [3:0] io;
    input [2:0] w;
    begin
      case (w)
        3'd4: shin = {s[3:0], io};
        3'd2: shin = {s[5:0], io[1], io[0]};
        default: shin = {s[6:0], io[0]};
      endcase
    end
  endfunction

  function is_array_rd;
    input [7:0] c;
    begin
      case (c)
        `SFC_OP_READ, `SFC_OP_FAST, `SFC_OP_DUAL_OUT, `SFC_OP_QUAD_OUT,
        `SFC_OP_DUAL_IO, `SFC_OP_QUAD_IO, `SFC_OP_WRAP_RD, `SFC_OP_DTR_QIO,
        `SFC_OP_SFDP, `SFC_OP_SEC_RD: is_array_rd = 1'b1;
        default: is_array_rd = 1'b0;
      endcase
    end
  endfunction

  // Dummy length in sampling edges; DDR counts both edges
  function [4:0] dummy_len;
    input [7:0] c;
    input q;
    begin
      case (c)
        `SFC_OP_FAST, `SFC_OP_SFDP: dummy_len = q ? `SFC_DUMMY_QPI : `SFC_DUMMY_SPI;
        `SFC_OP_DUAL_OUT, `SFC_OP_QUAD_OUT, `SFC_OP_SEC_RD: dummy_len = `SFC_DUMMY_SPI;
        `SFC_OP_QUAD_IO: dummy_len = `SFC_DUMMY_QIO;
        `SFC_OP_WRAP_RD: dummy_len = `SFC_DUMMY_QPI;
        `SFC_OP_DTR_QIO: dummy_len = `SFC_DUMMY_DTR
          + `SFC_DUMMY_DTR;
        default: dummy_len = 5'h00;
      endcase
    end
  endfunction

  function [2:0] first_ph;
    input [7:0] c;
    input busy;
    begin
      case (c)
        `SFC_OP_SR_RD_LO, `SFC_OP_SR_RD_HI, `SFC_OP_ID: first_ph = PH_DOUT;
        `SFC_OP_SR_WR, `SFC_OP_SET_WRAP: first_ph = PH_DIN;
        `SFC_OP_PGM, `SFC_OP_QPGM, `SFC_OP_SECT_ER, `SFC_OP_BLK32_ER,
        `SFC_OP_BLK64_ER, `SFC_OP_SEC_ER, `SFC_OP_SEC_PGM, `SFC_OP_ID_LEG: first_ph = PH_ADDR;
        default: first_ph = (is_array_rd(c) && !busy) ? PH_ADDR : PH_SKIP;
      endcase
    end
  endfunction

  function [2:0] after_addr;
    input [7:0] c;
    input [4:0] d;
    begin
      case (c)
        `SFC_OP_DUAL_IO, `SFC_OP_QUAD_IO, `SFC_OP_DTR_QIO: after_addr = PH_MODE;
        `SFC_OP_PGM, `SFC_OP_QPGM, `SFC_OP_SEC_PGM: after_addr = PH_DIN;
        `SFC_OP_SECT_ER, `SFC_OP_BLK32_ER, `SFC_OP_BLK64_ER, `SFC_OP_SEC_ER:
          after_addr = PH_SKIP;
        default: after_addr = (d != 5'h00) ? PH_DUMMY : PH_DOUT;
      endcase
    end
  endfunction

  function sec_ok;
    input [23:0] a;
    begin
      sec_ok = (a[23:16] == 8'h00) && (a[15:12] >= `SFC_SEC_MIN) &&
               (a[15:12] <= `SFC_SEC_MAX) && (a[11:10] == 2'b00);
    end
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  reg [5:0] pin_s1_q;
  reg [5:0] pin_s2_q;
  reg csn_s3_q;
  reg sclk_s3_q;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_q <= 6'h2F; // Serial clock idles low, so no false edge after reset
      pin_s2_q <= 6'h2F;
      csn_s3_q <= 1'b1;
      sclk_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {cs_n_i, sclk_i, io_i};
      pin_s2_q <= pin_s1_q;
      csn_s3_q <= pin_s2_q[5];
      sclk_s3_q <= pin_s2_q[4];
    end
  end

  wire csn_s = pin_s2_q[5];
  wire sclk_s = pin_s2_q[4];
  wire [3:0] io_s = pin_s2_q[3:0];
  wire cs_fall = ~csn_s & csn_s3_q;
  wire cs_rise = csn_s & ~csn_s3_q;
  wire frame = ~csn_s;
  wire sck_rise = sclk_s & ~sclk_s3_q;
  wire sck_fall = ~sclk_s & sclk_s3_q;

  reg [7:0] cmd_q;
  reg cmd_ok_q;
  reg [2:0] ph_q;
  reg [3:0] cnt_q;
  reg [1:0] nbyte_q;
  reg [23:0] addr_q;
  reg [4:0] dcnt_q;
  reg [7:0] sh_q;
  reg [3:0] clk_q;
  reg ddr_q;
  reg [7:0] wlo_q;
  reg [7:0] whi_q;
  reg [15:0] stat_q;
  reg wel_q;
  reg busy_q;
  reg arm_q;
  reg op_act_q;
  reg [23:0] wt_q;
  reg [7:0] ob_q;
  reg [2:0] ocnt_q;
  reg [1:0] obyte_q;
  wire fifo_ov;
  wire [7:0] fifo_od;

  // Edges on which this device samples and launches
  wire in_stb = frame & ~cs_fall & (sck_rise | (ddr_q & sck_fall));
  wire out_stb = frame & ~cs_fall & (sck_fall | (ddr_q & sck_rise));

  reg [2:0] w;
  reg [7:0] sh_nx;
  reg [3:0] cnt_nx;
  reg byte_done;
  reg [15:0] sview;
  reg [7:0] src;
  reg [7:0] ob_cur;
  reg [3:0] osum;
  reg [15:0] wr_new;
  reg wr_ok;
  reg fifo_pop;
  always @* begin
    w = lane_w(cmd_q, ph_q, quad_command_mode_o);
    sh_nx = shin(sh_q, io_s, w);
    cnt_nx = cnt_q + {1'b0, w};
    byte_done = in_stb && (cnt_nx == 4'h8);
    sview = {stat_q[15:2], wel_q, busy_q};
    // Output byte source
    case (cmd_q)
      `SFC_OP_SR_RD_LO: src = sview[7:0];
      `SFC_OP_SR_RD_HI: src = sview[15:8];
      `SFC_OP_ID: src = (obyte_q == 2'd0) ? MAKER_ID :
                        (obyte_q == 2'd1) ? DEV_ID[15:8] : DEV_ID[7:0];
      `SFC_OP_ID_LEG: src = (obyte_q == 2'd0) ? MAKER_ID : LEGACY_ID;
      default: src = fifo_ov ? fifo_od : 8'hFF; // Underrun reads as erased
    endcase
    ob_cur = (ocnt_q == 3'd0) ? src : ob_q;
    osum = {1'b0, ocnt_q} + {1'b0, w};
    fifo_pop = out_stb && (ph_q == PH_DOUT) && (ocnt_q == 3'd0) && is_array_rd(cmd_q);
    // Status write merge, protected bits kept
    if (nbyte_q == 2'd1) begin
      wr_new = (stat_q & ~`SFC_SR_WR_MASK) | ({stat_q[15:8], wlo_q} & `SFC_SR_WR_MASK);
      wr_new[`SFC_SR_CMP_BIT] = 1'b0;
    end else begin
      wr_new = (stat_q & ~`SFC_SR_WR_MASK) | ({whi_q, wlo_q} & `SFC_SR_WR_MASK);
    end
    wr_ok = (wel_q | arm_q) && !busy_q && (ph_q == PH_DIN) && (cnt_q == 4'h0) &&
            (nbyte_q == 2'd1 || nbyte_q == 2'd2);
  end

  // Command engine, flags and self-timed cycle
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_q <= 8'h00;
      cmd_ok_q <= 1'b0;
      ph_q <= PH_SKIP;
      cnt_q <= 4'h0;
      nbyte_q <= 2'd0;
      addr_q <= 24'h000000;
      dcnt_q <= 5'h00;
      sh_q <= 8'h00;
      clk_q <= 4'h0;
      ddr_q <= 1'b0;
      wlo_q <= 8'h00;
      whi_q <= 8'h00;
      stat_q <= `SFC_SR_RESET;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      arm_q <= 1'b0;
      op_act_q <= 1'b0;
      wt_q <= 24'h000000;
      quad_command_mode_o <= 1'b0;
      wrap_bits_o <= 3'h0;
      op_start_o <= 1'b0;
      op_code_o <= 8'h00;
      op_addr_o <= 24'h000000;
      rd_req_o <= 1'b0;
      rd_addr_o <= 24'h000000;
      pgm_data_o <= 8'h00;
      pgm_valid_o <= 1'b0;
      status_o <= `SFC_SR_RESET;
      write_latch_flag_o <= 1'b0;
      cycle_active_flag_o <= 1'b0;
    end else begin
      op_start_o <= 1'b0;
      rd_req_o <= 1'b0;
      pgm_valid_o <= 1'b0;
      status_o <= sview;
      write_latch_flag_o <= wel_q;
      cycle_active_flag_o <= busy_q;
      // Completion of the timed status write or of an array operation
      if (wt_q != 24'h000000) begin
        wt_q <= wt_q - 24'h000001;
      end
      if (wt_q == 24'h000001 || (op_act_q && op_done_i)) begin
        busy_q <= 1'b0;
        wel_q <= 1'b0;
        op_act_q <= 1'b0;
      end
      if (cs_fall) begin
        ph_q <= PH_CMD;
        cnt_q <= 4'h0;
        nbyte_q <= 2'd0;
        clk_q <= 4'h0;
        ddr_q <= 1'b0;
        cmd_ok_q <= 1'b0;
      end else if (cs_rise && cmd_ok_q) begin
        // Frame end actions; a frame without a whole opcode does nothing
        ph_q <= PH_SKIP;
        ddr_q <= 1'b0;
        if (cmd_q != `SFC_OP_SR_VOL) begin
          arm_q <= 1'b0;
        end
        case (cmd_q)
          `SFC_OP_SET_WRITE_LATCH_CMD_SET: wel_q <= 1'b1;
          `SFC_OP_SET_WRITE_LATCH_CMD_CLR: begin
            if (!busy_q) begin
              wel_q <= 1'b0;
            end
          end
          `SFC_OP_SR_VOL: arm_q <= 1'b1;
          `SFC_OP_QUAD_ON: quad_command_mode_o <= 1'b1;
          `SFC_OP_QUAD_OFF: quad_command_mode_o <= 1'b0;
          `SFC_OP_SR_WR: begin
            if (wr_ok) begin
              stat_q <= wr_new;
              if (!arm_q) begin
                busy_q <= 1'b1;
                wt_q <= TW_CYC;
              end
            end
          end
          default: begin
            // Only listed writes and erases start; unknown opcodes must never reach the array
            if (wel_q && !busy_q && !op_act_q &&
                ((cmd_q == `SFC_OP_CHIP_ER1) || (cmd_q == `SFC_OP_CHIP_ER2) ||
                 ((ph_q == PH_DIN) && ((cmd_q == `SFC_OP_PGM) || (cmd_q == `SFC_OP_QPGM) ||
                   (cmd_q == `SFC_OP_SEC_PGM && sec_ok(addr_q)))) ||
                 ((ph_q == PH_SKIP) && ((cmd_q == `SFC_OP_SECT_ER) ||
                   (cmd_q == `SFC_OP_BLK32_ER) || (cmd_q == `SFC_OP_BLK64_ER) ||
                   (cmd_q == `SFC_OP_SEC_ER && sec_ok(addr_q)))))) begin
              op_start_o <= 1'b1;
              op_code_o <= cmd_q;
              op_addr_o <= addr_q;
              op_act_q <= 1'b1;
              busy_q <= 1'b1;
            end
          end
        endcase
      end else if (in_stb && ph_q == PH_DUMMY) begin
        dcnt_q <= dcnt_q - 5'h01;
        if (dcnt_q <= 5'h01) begin
          ph_q <= PH_DOUT;
        end
      end else if (in_stb && ph_q != PH_DOUT && ph_q != PH_SKIP) begin
        sh_q <= sh_nx;
        cnt_q <= byte_done ? 4'h0 : cnt_nx;
        if (clk_q != 4'hF) begin
          clk_q <= clk_q + 4'h1;
        end
        if (cmd_q == `SFC_OP_SET_WRAP && ph_q == PH_DIN && clk_q == `SFC_WRAP_CLK) begin
          wrap_bits_o <= io_s[2:0];
        end
        if (byte_done) begin
          case (ph_q)
            PH_CMD: begin
              cmd_q <= sh_nx;
              cmd_ok_q <= 1'b1;
              ph_q <= first_ph(sh_nx, busy_q);
              clk_q <= 4'h0;
              ddr_q <= (sh_nx == `SFC_OP_DTR_QIO);
            end
            PH_ADDR: begin
              addr_q <= {addr_q[15:0], sh_nx};
              nbyte_q <= nbyte_q + 2'd1;
              if (nbyte_q == 2'd2) begin
                nbyte_q <= 2'd0;
                dcnt_q <= dummy_len(cmd_q, quad_command_mode_o);
                ph_q <= after_addr(cmd_q, dummy_len(cmd_q, quad_command_mode_o));
                if (is_array_rd(cmd_q) &&
                    (cmd_q != `SFC_OP_SEC_RD || sec_ok({addr_q[15:0], sh_nx}))) begin
                  rd_req_o <= 1'b1;
                  rd_addr_o <= {addr_q[15:0], sh_nx};
                end
              end
            end
            PH_MODE: ph_q <= (dcnt_q != 5'h00) ? PH_DUMMY : PH_DOUT;
            PH_DIN: begin
              if (nbyte_q == 2'd0) begin
                wlo_q <= sh_nx;
              end
              if (nbyte_q == 2'd1) begin
                whi_q <= sh_nx;
              end
              if (nbyte_q != 2'd3) begin
                nbyte_q <= nbyte_q + 2'd1; // Third byte poisons a status write
              end
              if (cmd_q == `SFC_OP_PGM || cmd_q == `SFC_OP_QPGM || cmd_q == `SFC_OP_SEC_PGM) begin
                pgm_data_o <= sh_nx;
                pgm_valid_o <= wel_q & ~busy_q;
              end
            end
            default: ph_q <= PH_SKIP;
          endcase
        end
      end
    end
  end

  // Output shifter, launched on the falling edge, and on both edges in DDR
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_o <= 4'h0;
      io_oe_n_o <= 4'hF;
      ob_q <= 8'h00;
      ocnt_q <= 3'd0;
      obyte_q <= 2'd0;
    end else if (!frame || cs_fall) begin
      io_o <= 4'h0;
      io_oe_n_o <= 4'hF;
      ocnt_q <= 3'd0;
      obyte_q <= 2'd0;
    end else if (out_stb && ph_q == PH_DOUT) begin
      case (w)
        3'd4: begin
          io_o <= ob_cur[7:4];
          io_oe_n_o <= 4'h0;
        end
        3'd2: begin
          io_o <= {2'b00, ob_cur[7], ob_cur[6]};
          io_oe_n_o <= 4'hC;
        end
        default: begin
          io_o <= {2'b00, ob_cur[7], 1'b0};
          io_oe_n_o <= 4'hD;
        end
      endcase
      ob_q <= ob_cur << w;
      ocnt_q <= osum[2:0];
      if (osum[3]) begin
        if ((cmd_q == `SFC_OP_ID && obyte_q == 2'd2) ||
            (cmd_q == `SFC_OP_ID_LEG && obyte_q == 2'd1)) begin
          obyte_q <= 2'd0;
        end else if (obyte_q != 2'd3) begin
          obyte_q <= obyte_q + 2'd1;
        end
      end
    end
  end

  // Read data buffer from the array side
  sfc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_rd_fifo (
    .clk_i(mclk_i),
    .rstn_i(rstn_i),
    .flush_i(cs_fall),
    .in_valid_i(rd_valid_i),
    .in_ready_o(rd_ready_o),
    .in_data_i(rd_data_i),
    .out_valid_o(fifo_ov),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_od)
  );
endmodule

/* File: sim/sfc_host_model.sv */
`timescale 1ns/1ps
module sfc_host_model (
  input wire mclk_i,
  input wire [3:0] dev_io_i,
  input wire [3:0] dev_oe_n_i,
  output reg cs_n_o = 1'b1,
  output reg sclk_o = 1'b0,
  output wire [3:0] io_o
);
  reg [3:0] hio = 4'h0;
  reg [3:0] hen = 4'h0;
  reg tgl = 1'b0;
  integer k;
  // Undriven lanes toggle so stale data never passes
  assign io_o = ~dev_oe_n_i & dev_io_i | dev_oe_n_i & (hen & hio | ~hen & {4{tgl}});
  always @(negedge mclk_i) tgl <= ~tgl;
  // Frame edges; serial clock rests low between frames
  task sel;
    begin
      repeat (13) @(negedge mclk_i);
      cs_n_o = 1'b0;
      repeat (30) @(negedge mclk_i);
    end
  endtask
  task desel;
    begin
      repeat (13) @(negedge mclk_i);
      cs_n_o = 1'b1;
      repeat (30) @(negedge mclk_i);
    end
  endtask
  // One byte msb first on w lanes; rd frees the lanes
  task xb(input [7:0] d, input [2:0] w, input rd, output [7:0] r);
    begin
      r = 8'h00;
      hen = rd ? 4'h0 : w == 3'h4 ? 4'hF : w == 3'h2 ? 4'h3 : 4'h1;
      for (k = 0; k < 8 / w; k = k + 1) begin
        hio = w == 3'h4 ? d[7:4] : w == 3'h2 ? {2'h0, d[7:6]} : {3'h0, d[7]};
        d = d << w;
        repeat (13) @(negedge mclk_i);
        r = w == 3'h4 ? {r[3:0], io_o} : w == 3'h2 ? {r[5:0], io_o[1:0]} : {r[6:0], io_o[1]};
        sclk_o = 1'b1;
        repeat (12) @(negedge mclk_i);
        sclk_o = 1'b0;
      end
    end
  endtask
endmodule

/* File: sim/sfc_cmd_status_props.sv */
`timescale 1ns/1ps
module sfc_cmd_status_props (
  input wire mclk_i,
  input wire rstn_i,
  input wire cs_n_i,
  input wire [3:0] io_oe_n_o,
  input wire [15:0] status_o,
  input wire write_latch_flag_o,
  input wire cycle_active_flag_o,
  input wire quad_command_mode_o,
  input wire op_start_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  flag_view_a: assert property (
    status_o[1:0] == {write_latch_flag_o, cycle_active_flag_o}) else $error("flag view");
  busy_start_a: assert property (
    $rose(cycle_active_flag_o) |-> cs_n_i && $past(cs_n_i, 3)) else $error("busy in frame");
  op_gate_a: assert property (
    op_start_o |-> write_latch_flag_o && !cycle_active_flag_o) else $error("op gate");
  done_clear_a: assert property (
    $fell(cycle_active_flag_o) |-> !write_latch_flag_o) else $error("latch kept");
  latch_fall_a: assert property (
    $fell(write_latch_flag_o) |-> cs_n_i || $past(cycle_active_flag_o)) else $error("latch fall");
  latch_busy_a: assert property (
    $fell(write_latch_flag_o) |-> !cycle_active_flag_o) else $error("latch cleared busy");
  lane_set_a: assert property (
    io_oe_n_o inside {4'hF, 4'hD, 4'hC, 4'h0}) else $error("lane set");
  quad_lanes_a: assert property (
    quad_command_mode_o && io_oe_n_o != 4'hF |-> io_oe_n_o == 4'h0) else $error("quad lanes");
  cover property ($rose(cycle_active_flag_o));
  cover property (op_start_o);
  cover property ($rose(quad_command_mode_o));
endmodule
bind sfc_cmd_status sfc_cmd_status_props props_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .cs_n_i(cs_n_i), .io_oe_n_o(io_oe_n_o), .status_o(status_o),
  .write_latch_flag_o(write_latch_flag_o), .cycle_active_flag_o(cycle_active_flag_o),
  .quad_command_mode_o(quad_command_mode_o), .op_start_o(op_start_o));

/* File: sim/test_sfc_cmd_status.sv */
`timescale 1ns/1ps
module test_sfc_cmd_status;
  localparam [7:0] MID = 8'hA5; // Arbitrary value
  localparam [15:0] DID = 16'h5A3C; // Arbitrary value
  localparam [7:0] LID = 8'h3C; // Arbitrary value
  reg mclk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg od = 1'b0, rv = 1'b0, tk = 1'b0;
  reg [7:0] dl = 8'h00, dat = 8'h00, r, n = 8'h00, pc = 8'h00, pg = 8'h00;
  reg [31:0] lop = 32'h0;
  integer num_errors = 0, num_checks = 0, i;
  wire cs, sck, write_latch_flag, bsy, qd, ops, rq, rdy, pv;
  wire [3:0] ii, io, oe;
  wire [15:0] st;
  wire [2:0] wb;
  wire [7:0] opc, pd;
  wire [23:0] opa, rda;
  always #2.5 mclk_i = ~mclk_i;
  sfc_cmd_status #(.TW_CYC(24'h0007D0), .MAKER_ID(MID), .DEV_ID(DID), .LEGACY_ID(LID)) uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cs_n_i(cs), .sclk_i(sck), .io_i(ii), .io_o(io),
    .io_oe_n_o(oe), .status_o(st), .write_latch_flag_o(write_latch_flag), .cycle_active_flag_o(bsy),
    .quad_command_mode_o(qd), .wrap_bits_o(wb), .op_start_o(ops), .op_code_o(opc),
    .op_addr_o(opa), .op_done_i(od), .rd_req_o(rq), .rd_addr_o(rda), .rd_data_i(dat),
    .rd_valid_i(rv), .rd_ready_o(rdy), .pgm_data_o(pd), .pgm_valid_o(pv));
  sfc_host_model h (.mclk_i(mclk_i), .dev_io_i(io), .dev_oe_n_i(oe), .cs_n_o(cs),
    .sclk_o(sck), .io_o(ii));
  // Array stand-in: ops end 8 cycles on, read data counts up
  always @(posedge mclk_i) tk <= rv & rdy;
  always @(negedge mclk_i) begin
    dl <= {dl[6:0], ops};
    od <= dl[7];
    if (ops) n <= n + 8'h01;
    if (ops) lop <= {opc, opa};
    if (pv) pc <= pc + 8'h01;
    if (pv) pg <= pd;
    if (rq) dat <= 8'h96;
    else if (tk) dat <= dat + 8'h01;
    rv <= rq | rv & ~cs;
  end
  task chk(input [47:0] got, input [47:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task s(input [7:0] d);
    h.xb(d, 3'h1, 1'b0, r);
  endtask
  task g(input [2:0] w);
    h.xb(8'h00, w, 1'b1, r);
  endtask
  task op(input [7:0] c, input [2:0] w);
    begin
      h.sel;
      h.xb(c, w, 1'b0, r);
      h.desel;
    end
  endtask
  task af(input [7:0] c, input [23:0] a);
    begin
      h.sel;
      s(c);
      s(a[23:16]);
      s(a[15:8]);
      s(a[7:0]);
    end
  endtask
  // Two status bytes in one frame
  task rs(input [7:0] c, input [7:0] m, input [7:0] e);
    begin
      h.sel;
      s(c);
      for (i = 0; i < 2; i = i + 1) begin
        g(3'h1);
        chk(r & m, e);
      end
      h.desel;
    end
  endtask
  task wr(input [7:0] lo, input two);
    begin
      h.sel;
      s(8'h01);
      s(lo);
      if (two) s(8'hFF);
      h.desel;
    end
  endtask
  task t_latch;
    begin
      chk({st, write_latch_flag, bsy, qd, oe, rdy}, {16'h0, 3'h0, 4'hF, 1'b1});
      h.sel;
      h.xb(8'h06, 3'h2, 1'b0, r);
      h.desel;
      chk(write_latch_flag, 1'b0);
      op(8'h06, 3'h1);
      chk(write_latch_flag, 1'b1);
      rs(8'h05, 8'hFF, 8'h02);
      rs(8'h35, 8'hFF, 8'h00);
      op(8'h04, 3'h1);
      chk(write_latch_flag, 1'b0);
    end
  endtask
  task t_wsr;
    begin
      wr(8'hFF, 1'b1);
      chk(bsy, 1'b0);
      op(8'h06, 3'h1);
      wr(8'hFF, 1'b1);
      chk(bsy, 1'b1);
      rs(8'h05, 8'h03, 8'h03);
      op(8'h04, 3'h1);
      chk(write_latch_flag, 1'b1);
      for (i = 0; i < 3000 && bsy !== 1'b0; i = i + 1) @(negedge mclk_i);
      chk({bsy, write_latch_flag}, 2'h0);
      rs(8'h35, 8'hFF, 8'h79);
      rs(8'h05, 8'hFF, 8'hFC);
      op(8'h06, 3'h1);
      wr(8'h04, 1'b0);
      for (i = 0; i < 3000 && bsy !== 1'b0; i = i + 1) @(negedge mclk_i);
      chk(bsy, 1'b0);
      rs(8'h35, 8'hFF, 8'h39);
      op(8'h06, 3'h1);
      h.sel;
      s(8'h01);
      s(8'h00);
      h.xb(8'h00, 3'h2, 1'b0, r);
      h.desel;
      rs(8'h05, 8'hFF, 8'h06);
      op(8'h04, 3'h1);
      // Volatile write: no busy, latch untouched; any other frame with a whole opcode cancels the arm
      op(8'h50, 3'h1);
      wr(8'h10, 1'b1);
      chk({bsy, write_latch_flag, st[7:0]}, {2'h0, 8'h10});
      op(8'h50, 3'h1);
      op(8'h05, 3'h1);
      wr(8'h20, 1'b1);
      chk(st[7:0], 8'h10);
    end
  endtask
  task t_id;
    begin
      h.sel;
      s(8'h9F);
      for (i = 0; i < 3; i = i + 1) begin
        g(3'h1);
        chk(r, i == 0 ? MID : i == 1 ? DID[15:8] : DID[7:0]);
      end
      h.desel;
      af(8'h90, 24'h0);
      g(3'h1);
      chk(r, MID);
      g(3'h1);
      chk(r, LID);
      h.desel;
    end
  endtask
  task t_prog;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        if (i == 1) op(8'h06, 3'h1);
        af(8'h02, 24'h001234);
        s(8'h5A);
        h.desel;
      end
      chk({n, lop, write_latch_flag}, {8'h01, 8'h02, 24'h001234, 1'b0});
      chk({pc, pg}, {8'h01, 8'h5A});
      op(8'h06, 3'h1);
      af(8'h44, 24'h001000);
      h.desel;
      chk({n, lop}, {8'h02, 8'h44, 24'h001000});
      op(8'h06, 3'h1);
      af(8'h44, 24'h004000);
      h.desel;
      chk(n, 8'h02);
      op(8'h04, 3'h1);
    end
  endtask
  // Dummy nibbles are all ones; only the seventh clock may land
  task t_wrap;
    begin
      h.sel;
      s(8'h77);
      for (i = 0; i < 3; i = i + 1) h.xb(8'hFF, 3'h4, 1'b0, r);
      h.xb(8'hAF, 3'h4, 1'b0, r);
      h.desel;
      chk({wb, n}, {3'h2, 8'h02});
    end
  endtask
  // Slow host lets the read buffer fill until it refuses
  task t_rd;
    begin
      af(8'h3B, 24'h000010);
      s(8'h00);
      g(3'h2);
      chk(r, 8'h96);
      g(3'h2);
      chk({r, rda, rdy}, {8'h97, 24'h000010, 1'b0});
      h.desel;
    end
  endtask
  task t_quad;
    begin
      op(8'h38, 3'h1);
      op(8'h06, 3'h4);
      h.sel;
      h.xb(8'h05, 3'h4, 1'b0, r);
      g(3'h4);
      chk({qd, r}, {1'b1, 8'h12});
      h.desel;
      op(8'h04, 3'h4);
      op(8'hFF, 3'h4);
      chk({qd, write_latch_flag}, 2'h0);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(negedge mclk_i);
    rstn_i = 1'b1;
    @(negedge mclk_i);
    t_latch;
    t_wsr;
    t_id;
    t_prog;
    t_rd;
    t_wrap;
    t_quad;
    stop_test;
  end
  // Watchdog well past the expected 123 us of traffic
  initial begin
    #450000;
    num_errors = num_errors + 1;
    stop_test;
  end
endmodule
